/* npic_ctrl.sv */
// nested priority interrupt controller top with register slave and entry sequencer
//
// Function
// [R1] four nesting levels, up to sixteen fixed vectors from FFE0h to FFFFh
// [R2] current level kept in two bits, bit 5 and bit 3 of condition codes
// [R3] codes: 10 level 0, 01 level 1, 00 level 2, 11 level 3
// [R4] accepted request waits for the current instruction to finish
// [R5] entry pushes program counter, index, accumulator, condition codes
// [R6] entry loads level bits with the serviced vector's programmed priority
// [R7] after stacking, program counter loads the vector address
// [R8] interrupt return restores the popped level bits
// [R9] highest software priority wins, ties go to highest hardware priority
// [R10] unserviced requests stay latched until they rank highest
// [R11] top-level line, reset and trap rank above all software levels
// [R12] non-maskable sources ignore level, enter at level 3, wake from halt
// [R13] trap taken on execution; its routine stays interruptible by top-level
// [R14] reset ranks highest; first code runs at level 3
// [R15] maskable request serviced only if enabled and above current level
// [R16] top-level line raised by a selected pin edge, entered like trap
// [R17] external edges latched, cleared on entry, sense set by software
// [R18] selected pins sharing one line are ored
// [R19] peripheral request needs its flag and its enable both set
// [R20] peripheral clear sequence drops the request latch, losing pending service
// [R21] any request wakes from wait; only halt-capable ones wake from halt
// [R22] after halt the first service is halt-capable, the others follow
// [R23] priority registers hold two bits per vector, reset all ones
// [R24] a pair written as level 0 keeps its previous value
// [R25] vector index and take strobe go to core at instruction boundaries
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "npic_defines.svh"
module npic_ctrl #(
  parameter int          NEXT      = 4,
  parameter int          PW        = 4,
  parameter int          EXT_BASE  = 2,
  parameter logic [13:0] HALT_MASK = 14'h00bf
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  // register bus
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [7:0]             s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  // core side
  input  wire npic_pkg::npic_core_req_t coreReq,
  output npic_pkg::npic_core_rsp_t      coreRsp,
  // external pins
  input  wire logic                   topLevelIrq,
  input  wire logic [NEXT*PW-1:0]     extPins,
  input  wire logic [NEXT*PW-1:0]     extPinSel,
  // peripheral requests
  input  wire logic [13:0]            periphFlag,
  input  wire logic [13:0]            periphEn,
  input  wire logic [13:0]            periphClear
);
  import npic_pkg::*;

  localparam int NV = `NPIC_NUM_VEC;

  typedef struct packed {
    npic_seq_t      seq;
    logic [1:0]     stackCnt;
    logic [3:0]     selIdx;
    logic [1:0]     selCode;
    logic [1:0]     level;
    logic           inTop;
    logic           haltExit;
    logic [NV-1:0]  periphPend;
    logic [31:0]    prio;
    logic [15:0]    sense;
    logic [NEXT-1:0] extAck;
    logic           topAck;
    npic_core_rsp_t rsp;
    logic           awRdy;
    logic           wRdy;
    logic           awHave;
    logic           wHave;
    logic [7:0]     awAddr;
    logic [31:0]    wData;
    logic [3:0]     wStrb;
    logic           bValid;
    logic [1:0]     bResp;
    logic           arRdy;
    logic           rValid;
    logic [31:0]    rData;
    logic [1:0]     rResp;
  } npic_state_t;

  npic_state_t   s_q;
  npic_state_t   s_d;
  logic [NEXT-1:0] extReq;
  logic          topReq;
  logic [NV-1:0] pend;
  logic [NV-1:0] eligible;
  logic          arbValid;
  logic [3:0]    arbIdx;
  logic [1:0]    arbCode;
  logic [31:0]   readData;
  logic          readHit;

  //////////////////////////////////////////////////////////////////////////
  // external line latches
  npic_ext_latch #(
    .NL (NEXT),
    .PW (PW)
  ) u_ext (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pins    (extPins),
    .pinSel  (extPinSel),
    .sense   (s_q.sense[2*NEXT-1:0]),
    .ack     (s_q.extAck),
    .req     (extReq)
  );  // [R17] [R18]

  // top-level line: one pin, its own sense and enable
  npic_ext_latch #(
    .NL (1),
    .PW (1)
  ) u_top (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pins    (topLevelIrq),
    .pinSel  (s_q.sense[`NPIC_SENSE_TOP_EN]),
    .sense   (s_q.sense[`NPIC_SENSE_TOP_LSB +: 2]),
    .ack     (s_q.topAck),
    .req     (topReq)
  );  // [R16]

  //////////////////////////////////////////////////////////////////////////
  // per-vector request assembly
  genvar v;
  generate
    for (v = 0; v < NV; v++) begin : g_vec
      if (v == 0) begin : g_top
        // a second top-level entry waits for the running one to return
        assign pend[v] = topReq & ~s_q.inTop;
      end else if (v >= EXT_BASE && v < EXT_BASE + NEXT) begin : g_ext
        assign pend[v] = extReq[v - EXT_BASE];
      end else begin : g_per
        assign pend[v] = s_q.periphPend[v];
      end
      // right after halt only halt-capable vectors compete
      assign eligible[v] = pend[v] & (~s_q.haltExit | HALT_MASK[v]);  // [R22]
    end
  endgenerate

  npic_arbiter #(
    .NV (NV)
  ) u_arb (
    .pend     (eligible),
    .prio     (s_q.prio[2*NV-1:0]),
    .curLevel (s_q.level),
    .valid    (arbValid),
    .idx      (arbIdx),
    .code     (arbCode)
  );  // [R9] [R11] [R15]

  //////////////////////////////////////////////////////////////////////////
  // read mux; status shows level at its condition code positions
  always_comb begin
    readData = 32'h0000_0000;
    readHit  = 1'b1;
    if (s_axi_araddr <= `NPIC_OFS_PRIO3 && s_axi_araddr[1:0] == 2'h0) begin
      readData[7:0] = s_q.prio[{s_axi_araddr[3:2], 3'h0} +: 8];
    end else if (s_axi_araddr == `NPIC_OFS_SENSE) begin
      readData[15:0] = s_q.sense;
    end else if (s_axi_araddr == `NPIC_OFS_STATUS) begin
      readData[`NPIC_COND_LVL_HI]    = s_q.level[1];  // [R2]
      readData[`NPIC_COND_LVL_LO]    = s_q.level[0];
      readData[`NPIC_STAT_IN_TOP]    = s_q.inTop;
      readData[`NPIC_STAT_HALT_EXIT] = s_q.haltExit;
      readData[`NPIC_STAT_PEND_LSB +: NV] = pend;
    end else begin
      readHit = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    // strobes last one cycle
    s_d.rsp.takeIrq    = 1'b0;
    s_d.rsp.stackPush  = 1'b0;
    s_d.rsp.vectorLoad = 1'b0;
    s_d.extAck         = '0;
    s_d.topAck         = 1'b0;

    // peripheral latch: flag and enable set it, clear sequence drops it
    s_d.periphPend = (s_q.periphPend | (periphFlag & periphEn)) & ~periphClear;  // [R19] [R20]

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_q.awRdy) begin
      s_d.awRdy  = 1'b0;
      s_d.awHave = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wRdy) begin
      s_d.wRdy  = 1'b0;
      s_d.wHave = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.awHave && s_q.wHave && !s_q.bValid) begin
      s_d.bValid = 1'b1;
      s_d.bResp  = `NPIC_RESP_OKAY;
      if (s_q.awAddr <= `NPIC_OFS_PRIO3 && s_q.awAddr[1:0] == 2'h0) begin
        // level 0 code never lands; upper pairs of the last register are fixed
        for (int p = 0; p < 4; p++) begin
          if (s_q.wStrb[0] && s_q.wData[2*p +: 2] != `NPIC_LVL_0 &&
              ({s_q.awAddr[3:2], 2'(p)} < 4'(NV))) begin
            s_d.prio[{s_q.awAddr[3:2], 3'(2*p)} +: 2] = s_q.wData[2*p +: 2];  // [R24]
          end
        end
      end else if (s_q.awAddr == `NPIC_OFS_SENSE) begin
        if (s_q.wStrb[0]) begin
          s_d.sense[7:0] = s_q.wData[7:0];
        end
        if (s_q.wStrb[1]) begin
          s_d.sense[15:8] = s_q.wData[15:8];
        end
      end else if (s_q.awAddr != `NPIC_OFS_STATUS) begin
        s_d.bResp = `NPIC_RESP_SLVERR;
      end
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
      s_d.awHave = 1'b0;
      s_d.wHave  = 1'b0;
      s_d.awRdy  = 1'b1;
      s_d.wRdy   = 1'b1;
    end

    // read channel: one outstanding read
    if (s_axi_arvalid && s_q.arRdy) begin
      s_d.arRdy  = 1'b0;
      s_d.rValid = 1'b1;
      s_d.rData  = readData;
      s_d.rResp  = readHit ? `NPIC_RESP_OKAY : `NPIC_RESP_SLVERR;
    end
    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
      s_d.arRdy  = 1'b1;
    end

    // wake: any request leaves wait, halt needs a capable one
    s_d.rsp.wakeUp = (coreReq.waitMode & (|pend)) |
                     (coreReq.haltMode & (|(pend & HALT_MASK)));  // [R21] [R12]
    if (coreReq.haltMode && (|(pend & HALT_MASK))) begin
      s_d.haltExit = 1'b1;
    end

    // entry sequencer
    case (s_q.seq)
      SEQ_RESET_VEC: begin
        // no stacking on reset; run at level 3 from the reset vector
        s_d.rsp.vectorLoad = 1'b1;
        s_d.rsp.vectorAddr = `NPIC_ADDR_RESET;
        s_d.rsp.vecIndex   = `NPIC_VEC_RESET;
        s_d.level          = `NPIC_LVL_3;  // [R14]
        s_d.seq            = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (coreReq.retExec) begin
          s_d.level = coreReq.retLevel;  // [R8]
          s_d.inTop = 1'b0;  // top-level runs at level 3: the next return is its own
        end else if (coreReq.lvlWrite) begin
          s_d.level = coreReq.lvlNew;  // [R3]
        end
        // requests are only taken between instructions
        if (coreReq.instrBoundary) begin  // [R4] [R25]
          if (coreReq.trapExec) begin
            s_d.rsp.takeIrq  = 1'b1;
            s_d.rsp.vecIndex = `NPIC_VEC_TRAP;
            s_d.selIdx       = `NPIC_VEC_TRAP;
            s_d.selCode      = `NPIC_LVL_3;  // [R13] [R12]
            s_d.stackCnt     = 2'h0;
            s_d.seq          = SEQ_STACK;
          end else if (arbValid) begin
            // losers keep their latches and compete again next boundary
            s_d.rsp.takeIrq  = 1'b1;  // [R10]
            s_d.rsp.vecIndex = arbIdx;
            s_d.selIdx       = arbIdx;
            s_d.selCode      = arbCode;
            s_d.stackCnt     = 2'h0;
            s_d.haltExit     = 1'b0;
            s_d.seq          = SEQ_STACK;
            if (arbIdx == 4'h0) begin
              s_d.topAck = 1'b1;
              s_d.inTop  = 1'b1;
            end
            for (int k = 0; k < NEXT; k++) begin
              s_d.extAck[k] = (arbIdx == 4'(EXT_BASE + k));  // [R17]
            end
          end
        end
      end
      SEQ_STACK: begin
        // one push per cycle: pc, x, a, then condition codes with the old level
        s_d.rsp.stackPush = 1'b1;
        s_d.rsp.stackItem = s_q.stackCnt;  // [R5]
        s_d.stackCnt      = s_q.stackCnt + 2'h1;
        if (s_q.stackCnt == `NPIC_STACK_LAST) begin
          s_d.seq = SEQ_VECTOR;
        end
      end
      SEQ_VECTOR: begin
        s_d.rsp.vectorLoad = 1'b1;
        s_d.level          = s_q.selCode;  // [R6]
        if (s_q.selIdx == `NPIC_VEC_TRAP) begin
          s_d.rsp.vectorAddr = `NPIC_ADDR_TRAP;
        end else begin
          s_d.rsp.vectorAddr = `NPIC_ADDR_VEC0 - {11'h000, s_q.selIdx, 1'b0};  // [R7] [R1]
        end
        s_d.seq = SEQ_RUN;
      end
      default: begin
        s_d.seq = SEQ_RUN;
      end
    endcase

    s_d.rsp.levelBitHi = s_d.level[1];
    s_d.rsp.levelBitLo = s_d.level[0];
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; reset enters at level 3
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q                <= '0;
      s_q.seq            <= SEQ_RESET_VEC;
      s_q.level          <= `NPIC_LVL_3;
      s_q.prio           <= `NPIC_RST_PRIO;  // [R23]
      s_q.sense          <= `NPIC_RST_SENSE;
      s_q.rsp.levelBitHi <= 1'b1;
      s_q.rsp.levelBitLo <= 1'b1;
      s_q.awRdy          <= 1'b1;
      s_q.wRdy           <= 1'b1;
      s_q.arRdy          <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign coreRsp       = s_q.rsp;
  assign s_axi_awready = s_q.awRdy;
  assign s_axi_wready  = s_q.wRdy;
  assign s_axi_bvalid  = s_q.bValid;
  assign s_axi_bresp   = s_q.bResp;
  assign s_axi_arready = s_q.arRdy;
  assign s_axi_rvalid  = s_q.rValid;
  assign s_axi_rdata   = s_q.rData;
  assign s_axi_rresp   = s_q.rResp;

endmodule

/* npic_defines.svh */
// constants of the interrupt controller
`ifndef NPIC_DEFINES_SVH
`define NPIC_DEFINES_SVH

// vector table
`define NPIC_NUM_VEC        14
`define NPIC_NUM_PAIR       16
`define NPIC_VEC_TRAP       4'he
`define NPIC_VEC_RESET      4'hf
`define NPIC_ADDR_RESET     16'hfffe
`define NPIC_ADDR_TRAP      16'hfffc
`define NPIC_ADDR_VEC0      16'hfffa

// level codes held in the two level bits
`define NPIC_LVL_0          2'h2
`define NPIC_LVL_1          2'h1
`define NPIC_LVL_2          2'h0
`define NPIC_LVL_3          2'h3

// level bit positions inside the condition code register image
`define NPIC_COND_LVL_HI    5
`define NPIC_COND_LVL_LO    3

// register byte offsets
`define NPIC_OFS_PRIO0      8'h00
`define NPIC_OFS_PRIO3      8'h0c
`define NPIC_OFS_SENSE      8'h10
`define NPIC_OFS_STATUS     8'h14

// reset values
`define NPIC_RST_PRIO       32'hffff_ffff
`define NPIC_RST_SENSE      16'h0000
`define NPIC_PRIO3_RO_MASK  8'hf0

// sense control field layout and codes
`define NPIC_SENSE_TOP_LSB  8
`define NPIC_SENSE_TOP_EN   10
`define NPIC_SENSE_FALL_LOW 2'h0
`define NPIC_SENSE_RISE     2'h1
`define NPIC_SENSE_FALL     2'h2
`define NPIC_SENSE_BOTH     2'h3

// status field positions
`define NPIC_STAT_IN_TOP    8
`define NPIC_STAT_HALT_EXIT 9
`define NPIC_STAT_PEND_LSB  16

// stacking sequence and bus answers
`define NPIC_STACK_LAST     2'h3
`define NPIC_RESP_OKAY      2'h0
`define NPIC_RESP_SLVERR    2'h2

`endif

/* npic_pkg.sv */
// shared types of the nested priority interrupt controller
package npic_pkg;

  // interrupt entry sequencer
  typedef enum logic [1:0] {SEQ_RESET_VEC, SEQ_RUN, SEQ_STACK, SEQ_VECTOR} npic_seq_t;

  // what the core tells the controller
  typedef struct packed {
    logic       instrBoundary;
    logic       trapExec;
    logic       retExec;
    logic [1:0] retLevel;
    logic       lvlWrite;
    logic [1:0] lvlNew;
    logic       haltMode;
    logic       waitMode;
  } npic_core_req_t;

  // what the controller tells the core
  typedef struct packed {
    logic        takeIrq;
    logic [3:0]  vecIndex;
    logic        stackPush;
    logic [1:0]  stackItem;
    logic        vectorLoad;
    logic [15:0] vectorAddr;
    logic        levelBitHi;
    logic        levelBitLo;
    logic        wakeUp;
  } npic_core_rsp_t;

  // level code to rank: 10 lowest, then 01, 00, 11 highest
  function automatic logic [2:0] npic_rank(input logic [1:0] code);
    case (code)
      2'h2:    npic_rank = 3'h0;
      2'h1:    npic_rank = 3'h1;
      2'h0:    npic_rank = 3'h2;
      default: npic_rank = 3'h3;
    endcase
  endfunction

endpackage

/* npic_ext_latch.sv */
// external line edge detection and request latches
`timescale 1ns/10ps
`include "npic_defines.svh"
module npic_ext_latch #(
  parameter int NL = 4,
  parameter int PW = 4
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // pins, selection and sense
  input  wire logic [NL*PW-1:0]  pins,
  input  wire logic [NL*PW-1:0]  pinSel,
  input  wire logic [2*NL-1:0]   sense,
  // service entry and request
  input  wire logic [NL-1:0]     ack,
  output logic      [NL-1:0]     req
);
  import npic_pkg::*;

  typedef struct packed {
    logic [NL*PW-1:0] prev;
    logic [NL-1:0]    latch;
    logic             armed;
  } npic_xl_state_t;

  npic_xl_state_t s_q;
  npic_xl_state_t s_d;
  logic [NL-1:0]  edgeHit;
  logic [NL-1:0]  lowHit;

  //////////////////////////////////////////////////////////////////////////
  // per line: selected pins of a group are ored together
  genvar l;
  generate
    for (l = 0; l < NL; l++) begin : g_line
      logic [PW-1:0] p;
      logic [PW-1:0] q;
      logic [PW-1:0] m;
      logic          rise;
      logic          fall;
      assign p = pins[l*PW +: PW];
      assign q = s_q.prev[l*PW +: PW];
      assign m = pinSel[l*PW +: PW];
      assign rise = |(p & ~q & m);
      assign fall = |(~p & q & m);
      assign lowHit[l] = |(~p & m);
      // edge choice from the sense field
      assign edgeHit[l] = s_q.armed & (
          (sense[2*l +: 2] == `NPIC_SENSE_RISE) ? rise :
          (sense[2*l +: 2] == `NPIC_SENSE_BOTH) ? (rise | fall) : fall);
      assign req[l] = s_q.latch[l] | (sense[2*l +: 2] == `NPIC_SENSE_FALL_LOW & lowHit[l]);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // latch: a new edge wins over the clear on entry
  always_comb begin
    s_d       = s_q;
    s_d.prev  = pins;
    s_d.armed = 1'b1;            // no edge seen in the first cycle after reset
    s_d.latch = edgeHit | (s_q.latch & ~ack);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* npic_arbiter.sv */
// priority decision: software rank first, fixed hardware order breaks ties
`timescale 1ns/10ps
`include "npic_defines.svh"
module npic_arbiter #(
  parameter int NV = 14
) (
  // candidates
  input  wire logic [NV-1:0]   pend,
  input  wire logic [2*NV-1:0] prio,
  input  wire logic [1:0]      curLevel,
  // choice
  output logic                 valid,
  output logic [3:0]           idx,
  output logic [1:0]           code
);
  import npic_pkg::*;

  logic [2:0] bestRank;
  logic [2:0] r;

  // scan from lowest hardware priority so that lower indices win ties
  always_comb begin
    bestRank = 3'h0;
    r        = 3'h0;
    valid    = 1'b0;
    idx      = 4'h0;
    code     = `NPIC_LVL_3;
    for (int v = NV - 1; v >= 0; v--) begin
      // top-level line outranks every software level
      r = (v == 0) ? 3'h4 : npic_rank(prio[2*v +: 2]);
      if (pend[v] && r > npic_rank(curLevel) && (!valid || r >= bestRank)) begin
        valid    = 1'b1;
        bestRank = r;
        idx      = 4'(v);
        code     = (v == 0) ? `NPIC_LVL_3 : prio[2*v +: 2];
      end
    end
  end

endmodule

/* npic_core_model.sv */
// behavioural core model
`timescale 1ns/10ps
module npic_core_model (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  // controller link
  input  wire npic_pkg::npic_core_rsp_t coreRsp,
  output npic_pkg::npic_core_req_t      coreReq,
  // bench commands
  input  wire logic                     trapCmd,
  input  wire logic                     retCmd,
  input  wire logic                     lvlCmd,
  input  wire logic [1:0]               cmdLvl,
  // observed entry
  output logic [2:0]                    pushCnt_q,
  output logic [15:0]                   pc_q
);
  import npic_pkg::*;
  logic busy_q;
  ////////////////////////////////////////
  // no boundary while the entry sequence owns the core
  always_comb begin
    coreReq = '0;
    coreReq.instrBoundary = !busy_q;
    coreReq.trapExec = trapCmd && !busy_q;
    coreReq.retExec = retCmd;
    coreReq.retLevel = cmdLvl;
    coreReq.lvlWrite = lvlCmd;
    coreReq.lvlNew = cmdLvl;
  end
  // a push out of item order stalls the count
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      pushCnt_q <= 3'h0;
      pc_q <= 16'h0;
    end else begin
      if (coreRsp.takeIrq) begin
        busy_q <= 1'b1;
        pushCnt_q <= 3'h0;
      end
      if (coreRsp.stackPush && coreRsp.stackItem == pushCnt_q[1:0])
        pushCnt_q <= pushCnt_q + 3'h1;
      if (coreRsp.vectorLoad) begin
        busy_q <= 1'b0;
        pc_q <= coreRsp.vectorAddr;
      end
    end
  end
endmodule

/* npic_ctrl_sva.sv */
// controller assertions
`timescale 1ns/10ps
module npic_ctrl_sva (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     srst,
  // register bus
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_bvalid,
  // core link and peripherals
  input wire npic_pkg::npic_core_req_t coreReq,
  input wire npic_pkg::npic_core_rsp_t coreRsp,
  input wire logic [13:0]              periphFlag,
  input wire logic [13:0]              periphEn
);
  import npic_pkg::*;
  logic [1:0]  lvl;
  logic [13:0] pReq;
  ////////////////////////////////////////
  // level pair, gated requests
  assign lvl = {coreRsp.levelBitHi, coreRsp.levelBitLo};
  assign pReq = periphFlag & periphEn;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  sequence s_push(logic [1:0] it);
    coreRsp.stackPush && coreRsp.stackItem == it;
  endsequence
  property p_entry;
    coreRsp.takeIrq |=> s_push(2'h0) ##1 s_push(2'h1) ##1 s_push(2'h2) ##1 s_push(2'h3)
      ##1 coreRsp.vectorLoad;
  endproperty
  a_entry: assert property (p_entry) else $error("entry order wrong");
  property p_trap;
    coreRsp.takeIrq && coreRsp.vecIndex == 4'he |->
      ##5 coreRsp.vectorLoad && coreRsp.vectorAddr == 16'hfffc && lvl == 2'h3;
  endproperty
  a_trap: assert property (p_trap) else $error("trap entry wrong");
  property p_addr;
    coreRsp.vectorLoad && coreRsp.vecIndex < 4'he |->
      coreRsp.vectorAddr == 16'hfffa - {11'h0, coreRsp.vecIndex, 1'b0};
  endproperty
  a_addr: assert property (p_addr) else $error("vector address wrong");
  property p_rst;
    coreRsp.vectorLoad && coreRsp.vecIndex == 4'hf |-> coreRsp.vectorAddr == 16'hfffe
      && lvl == 2'h3;
  endproperty
  a_rst: assert property (p_rst) else $error("reset vector wrong");
  property p_bound;
    coreRsp.takeIrq |-> $past(coreReq.instrBoundary);
  endproperty
  a_bound: assert property (p_bound) else $error("take off boundary");
  // returns inside an entry are ignored
  property p_ret;
    coreReq.retExec && !coreRsp.takeIrq && !coreRsp.stackPush && !coreRsp.vectorLoad
      |=> lvl == $past(coreReq.retLevel);
  endproperty
  a_ret: assert property (p_ret) else $error("return level wrong");
  property p_periph;
    coreRsp.takeIrq && coreRsp.vecIndex inside {4'h1, [4'h6:4'hd]} |->
      ((($past(pReq) | $past(pReq, 2) | $past(pReq, 3)) >> coreRsp.vecIndex) & 14'h1) != 0;
  endproperty
  a_periph: assert property (p_periph) else $error("ungated request taken");
  property p_bwait;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_bwait: assert property (p_bwait) else $error("address ready during response");
  c_trap: cover property (coreRsp.takeIrq && coreRsp.vecIndex == 4'he);
  c_periph: cover property (coreRsp.takeIrq && coreRsp.vecIndex == 4'h6);
  c_ret: cover property (coreReq.retExec);
endmodule
bind npic_ctrl npic_ctrl_sva chk_u (.*);

/* npic_ctrl_test.sv */
// self-checking bench of the nested priority interrupt controller
`timescale 1ns/10ps
module npic_ctrl_test;
  import npic_pkg::*;
  logic           ref_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic           s_axi_rready, trapCmd, retCmd, lvlCmd;
  logic [1:0]     s_axi_bresp, s_axi_rresp, cmdLvl, rs;
  logic [2:0]     pushCnt_q;
  logic [3:0]     s_axi_wstrb;
  logic [7:0]     s_axi_awaddr, s_axi_araddr;
  logic [13:0]    periphFlag, periphEn, periphClear;
  logic [15:0]    pc_q;
  logic [31:0]    s_axi_wdata, s_axi_rdata, rd;
  npic_core_req_t coreReq;
  npic_core_rsp_t coreRsp;
  int             fails = 0, nTests = 0, cyc = 0;
  ////////////////////////////////////////
  // unused pins idle
  npic_ctrl dut_u (.topLevelIrq(1'b0), .extPins(16'h0), .extPinSel(16'h0), .*);
  npic_core_model core_u (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // valid dropped right after its taking edge
  task automatic axiWr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic aw, w, b;
    @(posedge ref_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {aw, w, b} = 3'h6;
    while (!b) begin
      #1;
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(rs), 32'(er));
  endtask
  task automatic axiRd(logic [7:0] a);
    logic ar, r;
    @(posedge ref_clk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    {ar, r} = 2'h2;
    while (!r) begin
      #1;
      ar = ar && !s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_arvalid <= ar;
    end
    s_axi_rready <= 1'b0;
  endtask
  // one-cycle command to the core model
  task automatic core(logic [2:0] cmd, logic [1:0] l);
    @(posedge ref_clk);
    {trapCmd, retCmd, lvlCmd} <= cmd;
    cmdLvl <= l;
    @(posedge ref_clk);
    {trapCmd, retCmd, lvlCmd} <= 3'h0;
  endtask
  task automatic expTake(logic [3:0] ix, logic [15:0] ad, logic [1:0] lv, logic [2:0] np);
    do begin
      @(posedge ref_clk);
      #1;
    end while (coreRsp.vectorLoad !== 1'b1);
    chk("vecIndex", 32'(coreRsp.vecIndex), 32'(ix));
    chk("vectorAddr", 32'(coreRsp.vectorAddr), 32'(ad));
    chk("level", 32'({coreRsp.levelBitHi, coreRsp.levelBitLo}), 32'(lv));
    chk("pushes", 32'(pushCnt_q), 32'(np));
  endtask
  task automatic noTake(logic [15:0] ad);
    repeat (10) @(posedge ref_clk);
    chk("held pc", 32'(pc_q), 32'(ad));
    @(posedge ref_clk);
  endtask
  // registers, masking, nesting, trap
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {trapCmd, retCmd, lvlCmd, cmdLvl, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {periphFlag, periphEn, periphClear} = '0;
    s_axi_wstrb = 4'hf;
    srst = 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    expTake(4'hf, 16'hfffe, 2'h3, 3'h0);
    for (int k = 0; k < 4; k++) begin
      axiRd(8'(4 * k));
      chk("prio reset", rd, 32'hff);
    end
    axiRd(8'h20);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped resp", 32'(rs), 32'h2);
    axiWr(8'h20, 32'h1, 2'h2);
    axiWr(8'h00, 32'h64, 2'h0);
    axiRd(8'h00);
    chk("prio0", rd, 32'h74);
    axiWr(8'h0c, 32'h0, 2'h0);
    axiRd(8'h0c);
    chk("prio3", rd, 32'hf0);
    axiWr(8'h04, 32'h1f, 2'h0);
    $display("test registers done");
    periphFlag <= 14'h00c0;
    core(3'h1, 2'h2);
    noTake(16'hfffe);
    periphEn <= 14'h00c0;
    expTake(4'h7, 16'hffec, 2'h0, 3'h4);
    noTake(16'hffec);
    periphFlag <= 14'h0040;
    periphClear <= 14'h0080;
    @(posedge ref_clk);
    periphClear <= 14'h0;
    core(3'h2, 2'h2);
    expTake(4'h6, 16'hffee, 2'h1, 3'h4);
    core(3'h4, 2'h0);
    expTake(4'he, 16'hfffc, 2'h3, 3'h4);
    axiRd(8'h14);
    chk("status level", 32'({rd[5], rd[3]}), 32'h3);
    $display("test nesting done");
    conclude();
  end
endmodule
